// ### hdl/prm_paged_register_map.sv
// Paged register map decoder with device address and soft reset control.
`timescale 1ns/1ps
module prm_paged_register_map
	import prm_pkg::*;
(
	input  wire logic             ref_clk,
	input  wire logic             rst_b,
	input  wire logic [6:0]       strap_addr,
	input  wire logic             i2c_req,
	input  wire logic             i2c_wr,
	input  wire logic [7:0]       i2c_addr,
	input  wire logic [7:0]       i2c_wdata,
	input  wire logic             cc_req,
	input  wire logic             cc_wr,
	input  wire logic [7:0]       cc_addr,
	input  wire logic [7:0]       cc_wdata,
	output logic                  cc_grant,
	output logic [7:0]            rdata,
	output logic                  rvalid,
	output logic [6:0]            active_i2c_addr,
	output logic                  shared_wr,
	output logic                  shared_rd,
	output logic                  csi_wr,
	output logic                  csi_rd,
	output logic [3:0]            rx_wr_en,
	output logic [1:0]            rx_rd_sel,
	output logic                  rx_rd,
	output logic [7:0]            ext_addr,
	output logic [7:0]            ext_wdata,
	input  wire logic [7:0]       ext_rdata,
	output logic                  logic_rst,
	output logic                  config_rst,
	output logic                  rom_load_busy,
	output logic                  init_done
);

	// ***********************************************************
	// Request arbitration
	// ***********************************************************
	// Local I2C wins a same-cycle clash; the control channel sees no grant
	// and must hold its request for the next cycle.
	logic       req;
	logic       wr;
	logic [7:0] addr;
	logic [7:0] wdata;
	assign cc_grant = cc_req & ~i2c_req;
	assign req      = i2c_req | cc_req;
	assign wr       = i2c_req ? i2c_wr : cc_wr;
	assign addr     = i2c_req ? i2c_addr : cc_addr;
	assign wdata    = i2c_req ? i2c_wdata : cc_wdata;

	// ***********************************************************
	// Local registers
	// ***********************************************************
	logic       ovr_r;
	logic [6:0] addr_val_r;
	logic       strap_taken_r;
	logic [7:0] csi_page_r;
	logic [7:0] rx_page_r;
	logic [1:0] rst_req_r;
	logic       reload_req_r;
	logic [2:0] pulse_cnt_r;
	logic [4:0] load_cnt_r;
	logic       done_r;
	logic       cfg_clr;

	assign cfg_clr = config_rst;

	// The strap is caught by a clock edge after reset release, not by reset.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			strap_taken_r <= 1'b0;
			addr_val_r    <= 7'h00;
		end else if (!strap_taken_r || cfg_clr) begin
			strap_taken_r <= 1'b1;
			addr_val_r    <= strap_addr;
		end else if (req && wr && addr == PRM_OWN_ADDR_OFS) begin
			// The override bit of the same write decides, so that a write
			// that clears it never lets its address field become active.
			if (wdata[PRM_ADDR_OVR_BIT]) begin
				addr_val_r <= wdata[7:1];
			end else begin
				addr_val_r <= strap_addr;
			end
		end else if (!ovr_r) begin
			addr_val_r    <= strap_addr;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ovr_r <= 1'b0;
		end else if (cfg_clr) begin
			ovr_r <= 1'b0;
		end else if (req && wr && addr == PRM_OWN_ADDR_OFS) begin
			ovr_r <= wdata[PRM_ADDR_OVR_BIT];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			csi_page_r <= PRM_CSI_PAGE_RST;
			rx_page_r  <= PRM_RX_PAGE_RST;
		end else if (cfg_clr) begin
			csi_page_r <= PRM_CSI_PAGE_RST;
			rx_page_r  <= PRM_RX_PAGE_RST;
		end else if (req && wr) begin
			if (addr == PRM_CSI_PAGE_OFS) begin
				csi_page_r <= wdata;
			end
			if (addr == PRM_RX_PAGE_OFS) begin
				rx_page_r <= wdata;
			end
		end
	end

	assign active_i2c_addr = addr_val_r;

	// ***********************************************************
	// Soft reset sequencing
	// ***********************************************************
	// Request bits stay visible while their action runs, then clear.
	logic wr_rst;
	assign wr_rst = req && wr && addr == PRM_SOFT_RESET_CONTROL_OFS;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_req_r   <= PRM_SOFT_RESET_CONTROL_RST[1:0];
			pulse_cnt_r <= 3'h0;
		end else if (wr_rst && (wdata[PRM_FULL_RST_BIT] ||
				wdata[PRM_KEEP_RST_BIT])) begin
			rst_req_r   <= wdata[1:0];
			pulse_cnt_r <= 3'(PRM_RST_PULSE_CYC);
		end else if (pulse_cnt_r != 3'h0) begin
			pulse_cnt_r <= pulse_cnt_r - 3'h1;
			if (pulse_cnt_r == 3'h1) begin
				rst_req_r <= 2'h0;
			end
		end
	end

	assign logic_rst  = pulse_cnt_r != 3'h0;
	assign config_rst = logic_rst && rst_req_r[PRM_FULL_RST_BIT];

	// Hardware reset and a reload request both start the one loader counter; reset pulses run on pulse_cnt_r.
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			load_cnt_r   <= 5'(PRM_RELOAD_CYC);
			reload_req_r <= PRM_SOFT_RESET_CONTROL_RST[PRM_RELOAD_BIT];
			done_r       <= 1'b0;
		end else if (wr_rst && wdata[PRM_RELOAD_BIT]) begin
			load_cnt_r   <= 5'(PRM_RELOAD_CYC);
			reload_req_r <= 1'b1;
			done_r       <= 1'b0;
		end else if (load_cnt_r != 5'h00) begin
			load_cnt_r <= load_cnt_r - 5'h01;
			if (load_cnt_r == 5'h01) begin
				reload_req_r <= 1'b0;
				done_r       <= 1'b1;
			end
		end
	end

	assign rom_load_busy = load_cnt_r != 5'h00;
	assign init_done     = done_r;

	// ***********************************************************
	// Range decode
	// ***********************************************************
	function automatic logic in_rng(input logic [7:0] a,
			input logic [7:0] lo, input logic [7:0] hi);
		return a >= lo && a <= hi;
	endfunction

	logic     is_local;
	prm_tgt_t tgt;
	always_comb begin
		is_local = addr == PRM_OWN_ADDR_OFS || addr == PRM_SOFT_RESET_CONTROL_OFS ||
			addr == PRM_STATUS_OFS || addr == PRM_CSI_PAGE_OFS ||
			addr == PRM_RX_PAGE_OFS;
		if (is_local) begin
			tgt = PRM_TGT_LOCAL;
		end else if (in_rng(addr, PRM_CSI_LO, PRM_CSI_HI)) begin
			tgt = PRM_TGT_CSI;
		end else if (in_rng(addr, PRM_RX_LO, PRM_RX_HI) ||
				in_rng(addr, PRM_RX_DBG_LO, PRM_RX_DBG_HI)) begin
			tgt = PRM_TGT_RX;
		end else if (in_rng(addr, PRM_SHARED_LO, PRM_SHARED_HI) ||
				in_rng(addr, PRM_AEQ_LO, PRM_AEQ_HI) ||
				in_rng(addr, PRM_CSI_DBG_LO, PRM_CSI_DBG_HI) ||
				in_rng(addr, PRM_INDIRECT_LO, PRM_INDIRECT_HI) ||
				in_rng(addr, PRM_UPPER_LO, PRM_UPPER_HI) ||
				in_rng(addr, PRM_RX_ID_LO, PRM_RX_ID_HI) ||
				in_rng(addr, PRM_PORT_I2C_LO, PRM_PORT_I2C_HI)) begin
			tgt = PRM_TGT_SHARED;
		end else begin
			tgt = PRM_TGT_NONE;
		end
	end

	// ***********************************************************
	// Strobes to the register blocks
	// ***********************************************************
	logic csi_rd_ok;
	assign csi_rd_ok = ~csi_page_r[PRM_CSI_RD_BIT];
	assign shared_wr = req && wr && tgt == PRM_TGT_SHARED;
	assign shared_rd = req && !wr && tgt == PRM_TGT_SHARED;
	assign csi_wr    = req && wr && tgt == PRM_TGT_CSI &&
		csi_page_r[PRM_CSI_WR_BIT];
	assign csi_rd    = req && !wr && tgt == PRM_TGT_CSI && csi_rd_ok;
	assign rx_rd_sel = rx_page_r[PRM_RX_RSEL_LSB +: 2];
	assign rx_rd     = req && !wr && tgt == PRM_TGT_RX;

	genvar gp;
	generate
		for (gp = 0; gp < PRM_NUM_RX; gp++) begin : g_rx_wr
			assign rx_wr_en[gp] = req && wr && tgt == PRM_TGT_RX &&
				rx_page_r[gp];
		end
	endgenerate

	assign ext_addr  = addr;
	assign ext_wdata = wdata;

	// ***********************************************************
	// Read data return
	// ***********************************************************
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata  <= 8'h00;
			rvalid <= 1'b0;
		end else begin
			rvalid <= req && !wr;
			if (req && !wr) begin
				unique case (tgt)
					PRM_TGT_LOCAL: begin
						unique case (addr)
							PRM_OWN_ADDR_OFS:
								rdata <= {addr_val_r, ovr_r};
							PRM_SOFT_RESET_CONTROL_OFS:
								rdata <= {5'h00, reload_req_r, rst_req_r};
							PRM_STATUS_OFS:
								rdata <= 8'(done_r) << PRM_INIT_DONE_BIT;
							PRM_CSI_PAGE_OFS:
								rdata <= csi_page_r;
							default:
								rdata <= rx_page_r;
						endcase
					end
					PRM_TGT_SHARED, PRM_TGT_RX:
						rdata <= ext_rdata;
					PRM_TGT_CSI:
						rdata <= csi_rd_ok ? ext_rdata : 8'h00;
					default:
						rdata <= 8'h00;
				endcase
			end
		end
	end

endmodule

// ### include/prm_pkg.sv
// Package for the paged register map and soft reset controller.
package prm_pkg;
	// ***********************************************************
	// Register offsets
	// ***********************************************************
	localparam logic [7:0] PRM_OWN_ADDR_OFS   = 8'h00;
	localparam logic [7:0] PRM_SOFT_RESET_CONTROL_OFS  = 8'h01;
	localparam logic [7:0] PRM_STATUS_OFS     = 8'h04;
	localparam logic [7:0] PRM_CSI_PAGE_OFS   = 8'h32;
	localparam logic [7:0] PRM_RX_PAGE_OFS    = 8'h4C;
	// ***********************************************************
	// Address ranges
	// ***********************************************************
	localparam logic [7:0] PRM_SHARED_LO      = 8'h00;
	localparam logic [7:0] PRM_SHARED_HI      = 8'h32;
	localparam logic [7:0] PRM_CSI_LO         = 8'h33;
	localparam logic [7:0] PRM_CSI_HI         = 8'h3A;
	localparam logic [7:0] PRM_AEQ_LO         = 8'h40;
	localparam logic [7:0] PRM_AEQ_HI         = 8'h45;
	localparam logic [7:0] PRM_RX_LO          = 8'h46;
	localparam logic [7:0] PRM_RX_HI          = 8'h7F;
	localparam logic [7:0] PRM_CSI_DBG_LO     = 8'h90;
	localparam logic [7:0] PRM_CSI_DBG_HI     = 8'h9F;
	localparam logic [7:0] PRM_INDIRECT_LO    = 8'hB0;
	localparam logic [7:0] PRM_INDIRECT_HI    = 8'hB2;
	localparam logic [7:0] PRM_UPPER_LO       = 8'hB3;
	localparam logic [7:0] PRM_UPPER_HI       = 8'hBF;
	localparam logic [7:0] PRM_RX_DBG_LO      = 8'hD0;
	localparam logic [7:0] PRM_RX_DBG_HI      = 8'hDF;
	localparam logic [7:0] PRM_RX_ID_LO       = 8'hF0;
	localparam logic [7:0] PRM_RX_ID_HI       = 8'hF5;
	localparam logic [7:0] PRM_PORT_I2C_LO    = 8'hF8;
	localparam logic [7:0] PRM_PORT_I2C_HI    = 8'hFB;
	// ***********************************************************
	// Field positions and reset values
	// ***********************************************************
	localparam int         PRM_ADDR_OVR_BIT   = 0;
	localparam int         PRM_RELOAD_BIT     = 2;
	localparam int         PRM_FULL_RST_BIT   = 1;
	localparam int         PRM_KEEP_RST_BIT   = 0;
	localparam int         PRM_INIT_DONE_BIT  = 6;
	localparam int         PRM_CSI_RD_BIT     = 4;
	localparam int         PRM_CSI_WR_BIT     = 0;
	localparam int         PRM_RX_RSEL_LSB    = 4;
	localparam logic [7:0] PRM_SOFT_RESET_CONTROL_RST  = 8'h00;
	localparam logic [7:0] PRM_CSI_PAGE_RST   = 8'h00;
	localparam logic [7:0] PRM_RX_PAGE_RST    = 8'h00;
	localparam int         PRM_NUM_RX         = 4;
	// Timing: internal reset pulse width and ROM reload time.
	localparam int         PRM_RST_PULSE_CYC  = 4;
	localparam int         PRM_RELOAD_CYC     = 16;
	// ***********************************************************
	// Target selection codes
	// ***********************************************************
	typedef enum logic [2:0] {
		PRM_TGT_NONE   = 3'h0,
		PRM_TGT_LOCAL  = 3'h1,
		PRM_TGT_SHARED = 3'h2,
		PRM_TGT_CSI    = 3'h3,
		PRM_TGT_RX     = 3'h4
	} prm_tgt_t;
endpackage

// ### testbench/prm_cc_host.sv
// Control-channel master model issuing single-byte accesses.
`timescale 1ns/1ps
module prm_cc_host (
	input  wire logic       ref_clk,
	input  wire logic       cc_grant,
	output logic            cc_req,
	output logic            cc_wr,
	output logic [7:0]      cc_addr,
	output logic [7:0]      cc_wdata
);
	initial begin
		cc_req = 1'b0;
		cc_wr = 1'b0;
		cc_addr = 8'h00;
		cc_wdata = 8'h00;
	end
	// The request is held until a grant is seen at an edge or 20 edges pass, because the
	// local port wins any cycle in which both ask.
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge ref_clk);
		#2;
		cc_req = 1'b1;
		cc_wr = w;
		cc_addr = a;
		cc_wdata = d;
		for (int i = 0; i < 20; i++) begin
			@(posedge ref_clk);
			if (cc_grant === 1'b1) break;
		end
		#2;
		cc_req = 1'b0;
		cc_addr = ~a;
		cc_wdata = ~d;
	endtask
endmodule

// ### testbench/prm_map_checker.sv
// Port checker for the paged register map.
`timescale 1ns/1ps
module prm_map_checker
	import prm_pkg::*;
(
	input wire logic       ref_clk,
	input wire logic       rst_b,
	input wire logic       i2c_req,
	input wire logic       i2c_wr,
	input wire logic       cc_grant,
	input wire logic       rvalid,
	input wire logic       shared_wr,
	input wire logic       shared_rd,
	input wire logic       csi_wr,
	input wire logic       csi_rd,
	input wire logic [3:0] rx_wr_en,
	input wire logic       rx_rd,
	input wire logic [7:0] ext_addr,
	input wire logic       logic_rst,
	input wire logic       config_rst,
	input wire logic       rom_load_busy,
	input wire logic       init_done
);
	logic resv;
	logic any_st;
	assign resv = ext_addr inside {[8'h3B:8'h3F], [8'h80:8'h8F],
		[8'hA0:8'hAF], [8'hC0:8'hCF], [8'hE0:8'hEF], [8'hF6:8'hF7],
		[8'hFC:8'hFF]};
	assign any_st = shared_wr | shared_rd | csi_wr | csi_rd | rx_rd;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// ***********************************************************
	// Assertions
	// ***********************************************************
	grant_prio_a: assert property (i2c_req |-> !cc_grant)
		else $error("control channel granted beside local access");
	read_answer_a: assert property (i2c_req && !i2c_wr |=> rvalid)
		else $error("read not answered next cycle");
	csi_range_a: assert property ((csi_wr || csi_rd) |->
		ext_addr inside {[8'h33:8'h3A]}) else $error("stray csi strobe");
	rx_range_a: assert property ((rx_rd || rx_wr_en != 4'h0) |->
		ext_addr inside {[8'h46:8'h7F], [8'hD0:8'hDF]})
		else $error("stray receive strobe");
	shared_excl_a: assert property ((shared_wr || shared_rd) |->
		!csi_wr && !csi_rd && !rx_rd && rx_wr_en == 4'h0)
		else $error("shared access also paged");
	reserved_quiet_a: assert property ((i2c_req || cc_grant) && resv
		|-> !any_st && rx_wr_en == 4'h0) else $error("reserved strobe");
	rst_width_a: assert property ($rose(logic_rst) |->
		logic_rst[*4] ##1 !logic_rst) else $error("reset pulse width");
	cfg_rst_a: assert property (config_rst |-> logic_rst)
		else $error("config reset without logic reset");
	load_len_a: assert property ($rose(rom_load_busy) |->
		##15 rom_load_busy ##1 !rom_load_busy) else $error("reload length");
	load_done_a: assert property (rom_load_busy |-> !init_done)
		else $error("init done during reload");
	init_set_a: assert property ($fell(rom_load_busy) |->
		##[0:1] init_done) else $error("init done not set");
	cover property (rx_wr_en == 4'hF);
	cover property ($rose(config_rst));
	cover property (csi_wr);
endmodule

// ### testbench/tb.sv
// Self-checking bench for the paged register map.
`timescale 1ns/1ps
module tb;
	import prm_pkg::*;
	logic        ref_clk, rst_b, i2c_req, i2c_wr, cc_req, cc_wr, cc_grant;
	logic        rvalid, shared_wr, shared_rd, csi_wr, csi_rd, rx_rd;
	logic        logic_rst, config_rst, rom_load_busy, init_done;
	logic        sn_l, sn_c, sn_b;
	logic [7:0]  i2c_addr, i2c_wdata, cc_addr, cc_wdata, rdata;
	logic [7:0]  ext_addr, ext_wdata, ext_rdata, d;
	logic [6:0]  strap_addr, active_i2c_addr, a7;
	logic [3:0]  rx_wr_en, s_rx, s_st, en;
	logic [1:0]  rx_rd_sel, q;
	int          fails, total_checks;
	logic [31:0] seed = 32'd58173;
	logic [7:0]  ra [4] = '{8'h46, 8'h7F, 8'hD0, 8'hDF};
	logic [7:0]  sh [6] = '{8'h10, 8'h41, 8'h95, 8'hB1, 8'hF2, 8'hF9};
	logic [7:0]  rs [6] = '{8'h3C, 8'h85, 8'hA5, 8'hC5, 8'hE5, 8'hFD};
	prm_paged_register_map DUT (.ref_clk(ref_clk), .rst_b(rst_b),
		.strap_addr(strap_addr), .i2c_req(i2c_req), .i2c_wr(i2c_wr),
		.i2c_addr(i2c_addr), .i2c_wdata(i2c_wdata), .cc_req(cc_req),
		.cc_wr(cc_wr), .cc_addr(cc_addr), .cc_wdata(cc_wdata),
		.cc_grant(cc_grant), .rdata(rdata), .rvalid(rvalid),
		.active_i2c_addr(active_i2c_addr), .shared_wr(shared_wr),
		.shared_rd(shared_rd), .csi_wr(csi_wr), .csi_rd(csi_rd),
		.rx_wr_en(rx_wr_en), .rx_rd_sel(rx_rd_sel), .rx_rd(rx_rd),
		.ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata),
		.logic_rst(logic_rst), .config_rst(config_rst),
		.rom_load_busy(rom_load_busy), .init_done(init_done));
	prm_cc_host host_i (.ref_clk(ref_clk), .cc_grant(cc_grant),
		.cc_req(cc_req), .cc_wr(cc_wr), .cc_addr(cc_addr),
		.cc_wdata(cc_wdata));
	function automatic logic [7:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a,
		input logic [7:0] v);
		@(posedge ref_clk);
		#2;
		i2c_req = 1'b1;
		i2c_wr = w;
		i2c_addr = a;
		i2c_wdata = v;
		ext_rdata = xs();
		#5;
		s_rx = rx_wr_en;
		s_st = {shared_wr | shared_rd, csi_wr, csi_rd, rx_rd};
		@(posedge ref_clk);
		#2;
		i2c_req = 1'b0;
		i2c_addr = ~a;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00);
		chk(rvalid, 1'b1);
		chk(rdata, e);
	endtask
	// Waits for internal resets and reloads, noting what was seen.
	task automatic idle();
		{sn_l, sn_c, sn_b} = 3'b000;
		for (int i = 0; i < 60; i++) begin
			{sn_l, sn_c, sn_b} = {sn_l, sn_c, sn_b} |
				{logic_rst, config_rst, rom_load_busy};
			if (!logic_rst && !rom_load_busy) break;
			@(posedge ref_clk);
			#2;
		end
	endtask
	task automatic complete_run();
		$display("checks %0d fails %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	initial begin
		#200000;
		fails++;
		complete_run();
	end
	initial begin
		{rst_b, i2c_req, i2c_wr, i2c_addr, i2c_wdata, ext_rdata} = '0;
		{fails, total_checks} = '0;
		d = xs();
		strap_addr = d[6:0];
		repeat (3) @(posedge ref_clk);
		#2;
		rst_b = 1'b1;
		idle();
		rd(PRM_OWN_ADDR_OFS, {strap_addr, 1'b0});
		rd(PRM_SOFT_RESET_CONTROL_OFS, PRM_SOFT_RESET_CONTROL_RST);
		rd(PRM_STATUS_OFS, 8'h40);
		d = xs();
		a7 = d[6:0];
		acc(1'b1, PRM_OWN_ADDR_OFS, {a7, 1'b1});
		chk(active_i2c_addr, a7);
		rd(PRM_OWN_ADDR_OFS, {a7, 1'b1});
		acc(1'b1, PRM_OWN_ADDR_OFS, {~a7, 1'b0});
		chk(active_i2c_addr, strap_addr);
		for (int p = 0; p < 4; p++) begin
			d = xs();
			en = (p == 0) ? 4'h0 : d[3:0];
			acc(1'b1, PRM_RX_PAGE_OFS, {2'b00, 2'(p), en});
			acc(1'b1, ra[p], xs());
			chk(s_rx, en);
			acc(1'b0, ra[p], 8'h00);
			chk({rx_rd_sel, s_st}, {2'(p), 4'b0001});
			chk(rdata, ext_rdata);
			q = 2'(p);
			acc(1'b1, PRM_CSI_PAGE_OFS, {3'b000, q[1], 3'b000, q[0]});
			acc(1'b1, 8'h33 + 8'(7 * q[0]), xs());
			chk(s_st, {1'b0, q[0], 2'b00});
			acc(1'b0, 8'h3A - 8'(7 * q[0]), 8'h00);
			chk(s_st, {2'b00, ~q[1], 1'b0});
		end
		for (int i = 0; i < 6; i++) begin
			acc(1'b1, sh[i], xs());
			chk({s_rx, s_st}, 8'h08);
			acc(1'b0, sh[i], 8'h00);
			chk({rvalid, rdata}, {1'b1, ext_rdata});
			acc(1'b1, rs[i], xs());
			chk({s_rx, s_st}, 8'h00);
			rd(rs[i], 8'h00);
		end
		fork
			acc(1'b0, PRM_SOFT_RESET_CONTROL_OFS, 8'h00);
			host_i.xfer(1'b0, PRM_OWN_ADDR_OFS, 8'h00);
		join
		chk({rvalid, rdata}, {1'b1, strap_addr, 1'b0});
		host_i.xfer(1'b1, PRM_RX_PAGE_OFS, 8'h1C);
		acc(1'b1, PRM_OWN_ADDR_OFS, {a7, 1'b1});
		// Local I2C port restarts logic with the keeping reset first.
		acc(1'b1, PRM_SOFT_RESET_CONTROL_OFS, 8'h01);
		idle();
		chk({sn_l, sn_c}, 2'b10);
		acc(1'b1, 8'h50, xs());
		chk({s_rx, active_i2c_addr}, {4'hC, a7});
		acc(1'b1, PRM_SOFT_RESET_CONTROL_OFS, 8'h02);
		idle();
		chk({sn_l, sn_c}, 2'b11);
		rd(PRM_SOFT_RESET_CONTROL_OFS, 8'h00);
		acc(1'b1, 8'h50, xs());
		chk({s_rx, active_i2c_addr}, {4'h0, strap_addr});
		acc(1'b1, PRM_SOFT_RESET_CONTROL_OFS, 8'h04);
		idle();
		chk(sn_b, 1'b1);
		acc(1'b0, PRM_STATUS_OFS, 8'h00);
		chk(rdata & 8'h40, 8'h40);
		rd(PRM_SOFT_RESET_CONTROL_OFS, 8'h00);
		complete_run();
	end
endmodule
bind prm_paged_register_map prm_map_checker chk_i (.ref_clk(ref_clk),
	.rst_b(rst_b), .i2c_req(i2c_req), .i2c_wr(i2c_wr),
	.cc_grant(cc_grant), .rvalid(rvalid), .shared_wr(shared_wr),
	.shared_rd(shared_rd), .csi_wr(csi_wr), .csi_rd(csi_rd),
	.rx_wr_en(rx_wr_en), .rx_rd(rx_rd), .ext_addr(ext_addr),
	.logic_rst(logic_rst), .config_rst(config_rst),
	.rom_load_busy(rom_load_busy), .init_done(init_done));
